//--- hdl/bpg_bert.sv
// Bit-error-rate pattern generator and checker with APB registers
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module bpg_bert
    import bpg_pkg::*;
#(
    parameter int BIT_CNT_W = 32,
    parameter int ERR_CNT_W = 24
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit payload
    input wire logic txValid,
    output logic txBit,
    // Receive payload
    input wire logic rxValid,
    input wire logic rxBit,
    // Manual error input and interrupt
    input wire logic manualErrorInsertIn,
    output logic irqN
);

    // ==========================================================
    // Helper functions
    function automatic logic [31:0] len_mask(input logic [4:0] lenN);
        len_mask = 32'hFFFF_FFFF >> (5'd31 - lenN);
    endfunction
    function automatic logic pat_feedback(input logic [31:0] sr, input bpg_ctrl_s c);
        logic f;
        f = 1'b0;
        if (c.repetitive) begin
            f = sr[c.lenN];
        end else begin
            if (c.quasiRandomMode) begin
                f = sr[QUASI_RANDOM_MODE_TAP_A] ^ sr[QUASI_RANDOM_MODE_TAP_B];
            end else begin
                f = sr[c.lenN] ^ sr[c.tapY];
            end
            if (sr[GEN_W-2:0] == '0) begin
                f = 1'b1;
            end
        end
        pat_feedback = f;
    endfunction
    function automatic logic pat_output(input logic [31:0] sr, input bpg_ctrl_s c);
        pat_output = pat_feedback(sr, c);
        if (c.quasiRandomMode && !c.repetitive && sr[QUASI_RANDOM_MODE_ZERO_RUN-1:0] == '0) begin
            pat_output = 1'b1;
        end
    endfunction
    function automatic logic [23:0] pow10(input logic [2:0] n);
        case (n)
            3'd1: pow10 = 24'd10;
            3'd2: pow10 = 24'd100;
            3'd3: pow10 = 24'd1000;
            3'd4: pow10 = 24'd10000;
            3'd5: pow10 = 24'd100000;
            3'd6: pow10 = 24'd1000000;
            3'd7: pow10 = 24'd10000000;
            default: pow10 = 24'd0;
        endcase
    endfunction

    // ==========================================================
    // Register bus
    bpg_ctrl_s ctrl;
    bpg_ctrl_s wrCtrl;
    logic [31:0] seed;
    logic [NUM_FLAGS-1:0] latched;
    logic [NUM_FLAGS-1:0] irqEn;
    logic [NUM_FLAGS-1:0] events;
    logic [NUM_FLAGS-1:0] clearMask;
    logic [NUM_FLAGS-1:0] live;
    logic [BIT_CNT_W-1:0] bitCnt;
    logic [BIT_CNT_W-1:0] bitCountHeld;
    logic [ERR_CNT_W-1:0] errCnt;
    logic [ERR_CNT_W-1:0] errCountHeld;
    logic [31:0] rdMux;
    logic mapped;
    logic wrAcc;
    logic rdAcc;
    logic perfReq;
    logic singleReq;
    assign wrCtrl = bpg_ctrl_s'(pwdata);
    assign wrAcc = psel && penable && pwrite;
    assign rdAcc = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign perfReq = ce && wrAcc && paddr == OFS_CTRL && wrCtrl.perfUpdateRequest;
    assign singleReq = ce && wrAcc && paddr == OFS_CTRL && wrCtrl.singleErrReq;
    always_comb begin
        rdMux = '0;
        mapped = 1'b1;
        case (paddr)
            OFS_CTRL: rdMux = ctrl;
            OFS_SEED: rdMux = seed;
            OFS_LIVE: rdMux[NUM_FLAGS-1:0] = live;
            OFS_LATCHED: rdMux[NUM_FLAGS-1:0] = latched;
            OFS_IRQ_EN: rdMux[NUM_FLAGS-1:0] = irqEn;
            OFS_BIT_COUNT: rdMux[BIT_CNT_W-1:0] = bitCountHeld;
            OFS_ERR_COUNT: rdMux[ERR_CNT_W-1:0] = errCountHeld;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;
    // Read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (ce && psel && !penable) begin
            prdata <= rdMux;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= bpg_ctrl_s'(CTRL_RESET);
            seed <= SEED_RESET;
            irqEn <= '0;
        end else if (ce && wrAcc) begin
            case (paddr)
                OFS_CTRL: begin
                    ctrl <= wrCtrl;
                    ctrl.reserved <= '0;
                    ctrl.perfUpdateRequest <= 1'b0;
                    ctrl.singleErrReq <= 1'b0;
                end
                OFS_SEED: seed <= pwdata;
                OFS_IRQ_EN: irqEn <= pwdata[NUM_FLAGS-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Latched flags and interrupt
    logic perfStat;
    logic nzPrev;
    logic oosPrev;
    logic outOfSync;
    logic errorCountNonzero;
    logic rxMismatch;
    logic countBit;
    assign errorCountNonzero = errCnt != '0;
    assign live = {outOfSync, errorCountNonzero, countBit && rxMismatch, perfStat};
    assign events[FLG_PERF] = perfReq;
    assign events[FLG_BITERR] = countBit && rxMismatch;
    assign events[FLG_NONZERO] = errorCountNonzero && !nzPrev;
    assign events[FLG_SYNC] = outOfSync && !oosPrev;
    always_comb begin
        clearMask = '0;
        if (ce && paddr == OFS_LATCHED) begin
            if (ctrl.writeOneClearSel && wrAcc) begin
                clearMask = pwdata[NUM_FLAGS-1:0];
            end else if (!ctrl.writeOneClearSel && rdAcc) begin
                clearMask = prdata[NUM_FLAGS-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latched <= '0;
            perfStat <= 1'b0;
            nzPrev <= 1'b0;
            oosPrev <= 1'b1;
        end else if (ce) begin
            // A new event wins over a clear in the same cycle
            latched <= (latched & ~clearMask) | events;
            perfStat <= perfReq;
            nzPrev <= errorCountNonzero;
            oosPrev <= outOfSync;
        end
    end
    assign irqN = !(|(latched & irqEn));

    // ==========================================================
    // Transmit generator and error insertion
    logic [31:0] txSr;
    logic txLoadPrev;
    logic txLoadRise;
    logic [2:0] manSync;
    logic manEdge;
    logic errPending;
    logic [23:0] rateCnt;
    logic rateHit;
    assign txLoadRise = ctrl.txPatternLoad && !txLoadPrev;
    assign manEdge = manSync[2] ^ manSync[1];
    assign rateHit = ctrl.errRate != '0 && rateCnt == pow10(ctrl.errRate) - 24'd1;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            manSync <= '0;
        end else if (ce) begin
            manSync <= {manSync[1:0], manualErrorInsertIn};
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            errPending <= 1'b0;
        end else if (ce) begin
            errPending <= (errPending && !txValid)
                || (ctrl.manualSel ? manEdge : singleReq);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rateCnt <= '0;
        end else if (ce && txValid) begin
            if (ctrl.errRate == '0 || rateHit) begin
                rateCnt <= '0;
            end else begin
                rateCnt <= rateCnt + 24'd1;
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txSr <= '0;
            txLoadPrev <= 1'b0;
            txBit <= 1'b0;
        end else if (ce) begin
            txLoadPrev <= ctrl.txPatternLoad;
            if (txLoadRise) begin
                txSr <= seed & len_mask(ctrl.lenN);
            end else if (txValid) begin
                txSr <= {txSr[GEN_W-2:0], pat_feedback(txSr, ctrl)};
                txBit <= pat_output(txSr, ctrl) ^ (errPending || rateHit)
                    ^ ctrl.invert;
            end
        end
    end

    // ==========================================================
    // Receive sync machine
    bpg_rx_e rxState;
    logic [31:0] rxSr;
    logic [31:0] rxShiftIn;
    logic [4:0] rxCnt;
    logic [5:0] winCnt;
    logic [2:0] winErr;
    logic rxLoadPrev;
    logic rxLoadRise;
    logic repHit;
    logic resyncHit;
    assign rxLoadRise = ctrl.rxPatternLoad && !rxLoadPrev;
    assign rxShiftIn = {rxSr[GEN_W-2:0], rxBit};
    assign repHit = (rxShiftIn & len_mask(ctrl.lenN)) == (seed & len_mask(ctrl.lenN));
    assign rxMismatch = rxBit != pat_output(rxSr, ctrl);
    assign outOfSync = rxState != RX_SYNC;
    assign countBit = ce && rxValid && !outOfSync;
    assign resyncHit = rxMismatch && winErr >= RESYNC_ERRS - 3'd1
        && !ctrl.resyncDisable;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxLoadPrev <= 1'b0;
        end else if (ce) begin
            rxLoadPrev <= ctrl.rxPatternLoad;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxState <= RX_LOAD;
            rxSr <= '0;
            rxCnt <= '0;
        end else if (ce) begin
            if (rxLoadRise) begin
                rxState <= RX_LOAD;
                rxCnt <= '0;
            end else if (rxValid) begin
                case (rxState)
                    RX_LOAD: begin
                        rxSr <= rxShiftIn;
                        rxCnt <= rxCnt + 5'd1;
                        if (ctrl.repetitive ? repHit : rxCnt == SYNC_LAST) begin
                            rxState <= RX_CHECK;
                            rxCnt <= '0;
                        end
                    end
                    RX_CHECK: begin
                        rxSr <= {rxSr[GEN_W-2:0], pat_feedback(rxSr, ctrl)};
                        rxCnt <= rxCnt + 5'd1;
                        if (rxMismatch) begin
                            rxState <= RX_LOAD;
                            rxCnt <= '0;
                        end else if (rxCnt == SYNC_LAST) begin
                            rxState <= RX_SYNC;
                        end
                    end
                    RX_SYNC: begin
                        rxSr <= {rxSr[GEN_W-2:0], pat_feedback(rxSr, ctrl)};
                        if (resyncHit) begin
                            rxState <= RX_LOAD;
                            rxCnt <= '0;
                        end
                    end
                    default: rxState <= RX_LOAD;
                endcase
            end
        end
    end
    // Mismatch count within the current 64-bit window
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            winCnt <= '0;
            winErr <= '0;
        end else if (ce) begin
            if (outOfSync) begin
                winCnt <= '0;
                winErr <= '0;
            end else if (rxValid) begin
                winCnt <= winCnt + 6'd1;
                if (winCnt == WIN_LAST) begin
                    winErr <= '0;
                end else if (rxMismatch && winErr != WIN_ERR_MAX) begin
                    winErr <= winErr + 3'd1;
                end
            end
        end
    end

    // ==========================================================
    // Counters and monitor update
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bitCnt <= '0;
            errCnt <= '0;
            bitCountHeld <= '0;
            errCountHeld <= '0;
        end else if (ce) begin
            if (perfReq) begin
                bitCountHeld <= bitCnt;
                errCountHeld <= errCnt;
                bitCnt <= BIT_CNT_W'(countBit);
                errCnt <= ERR_CNT_W'(countBit && rxMismatch);
            end else if (countBit) begin
                bitCnt <= bitCnt + 1'b1;
                if (rxMismatch) begin
                    errCnt <= errCnt + 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_irq_on_flag: assert property (
        ce && events[FLG_BITERR] && irqEn[FLG_BITERR] |=> !irqN)
        else $error("irqN not low after enabled bit error");
    a_irq_holds: assert property (
        (latched & irqEn) != '0 && clearMask == '0 |=> !irqN)
        else $error("irqN released with enabled flag pending");
    a_w1c_clear: assert property (
        ce && ctrl.writeOneClearSel && wrAcc && paddr == OFS_LATCHED
        && pwdata[FLG_PERF] && !events[FLG_PERF] |=> !latched[FLG_PERF])
        else $error("write one did not clear flag");
    a_cor_clear: assert property (
        ce && !ctrl.writeOneClearSel && rdAcc && paddr == OFS_LATCHED
        && prdata[FLG_SYNC] && !events[FLG_SYNC] |=> !latched[FLG_SYNC])
        else $error("read did not clear flag");
    a_sync_entry: assert property (
        $fell(outOfSync) |-> $past(rxState) == RX_CHECK && $past(rxCnt) == SYNC_LAST)
        else $error("sync entered without 32 matches");
    a_count_hold: assert property (
        outOfSync && !perfReq |=> $stable(bitCnt) && $stable(errCnt))
        else $error("counter moved while out of sync");
    a_count_step: assert property (
        countBit && rxMismatch && !perfReq
        |=> bitCnt == $past(bitCnt) + 1'b1 && errCnt == $past(errCnt) + 1'b1)
        else $error("counters did not step on bit error");
    a_resync_go: assert property (
        countBit && resyncHit && !rxLoadRise |=> outOfSync)
        else $error("no resync after six window errors");
    a_no_resync: assert property (
        ce && ctrl.resyncDisable && !outOfSync && !rxLoadRise |=> !outOfSync)
        else $error("resync despite disable");
    a_perf_copy: assert property (
        perfReq |=> bitCountHeld == $past(bitCnt) && errCountHeld == $past(errCnt))
        else $error("monitor update did not copy counters");
    a_tx_seed: assert property (
        ce && txLoadRise |=> txSr == $past(seed & len_mask(ctrl.lenN)))
        else $error("transmit generator not preset");
    c_sync_reached: cover property ($fell(outOfSync));
    c_sync_lost: cover property ($rose(outOfSync) ##[1:200] $fell(outOfSync));
    c_irq_low: cover property ($fell(irqN));
    c_rate_error: cover property (ce && txValid && rateHit);

endmodule

//--- pkg/bpg_pkg.sv
// Constants, register layout and types for the bit-error-rate test block
package bpg_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SEED = 8'h04;
    localparam logic [7:0] OFS_LIVE = 8'h08;
    localparam logic [7:0] OFS_LATCHED = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_BIT_COUNT = 8'h14;
    localparam logic [7:0] OFS_ERR_COUNT = 8'h18;

    // ==========================================================
    // Flag positions in live, latched and enable registers
    localparam int FLG_PERF = 0;
    localparam int FLG_BITERR = 1;
    localparam int FLG_NONZERO = 2;
    localparam int FLG_SYNC = 3;
    localparam int NUM_FLAGS = 4;

    // ==========================================================
    // Generator and sync figures
    localparam int GEN_W = 32;
    localparam int QUASI_RANDOM_MODE_TAP_A = 16;
    localparam int QUASI_RANDOM_MODE_TAP_B = 19;
    localparam int QUASI_RANDOM_MODE_ZERO_RUN = 14;
    localparam logic [4:0] SYNC_LAST = 5'd31;
    localparam logic [5:0] WIN_LAST = 6'd63;
    localparam logic [2:0] RESYNC_ERRS = 3'd6;
    localparam logic [2:0] WIN_ERR_MAX = 3'd7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SEED_RESET = 32'hFFFF_FFFF;

    // ==========================================================
    // Control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [8:0] reserved;
        logic [2:0] errRate;
        logic [4:0] tapY;
        logic [4:0] lenN;
        logic perfUpdateRequest;
        logic singleErrReq;
        logic rxPatternLoad;
        logic txPatternLoad;
        logic writeOneClearSel;
        logic manualSel;
        logic resyncDisable;
        logic invert;
        logic repetitive;
        logic quasiRandomMode;
    } bpg_ctrl_s;

    typedef enum logic [1:0] {
        RX_LOAD = 2'b00,
        RX_CHECK = 2'b01,
        RX_SYNC = 2'b10
    } bpg_rx_e;

endpackage

//--- bench/bpg_line_model.sv
// Line model: loops transmit payload back to the receiver, with optional bit flips
`timescale 1ns/1ps
module bpg_line_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Transmit side of the block
    input wire logic txValid,
    input wire logic txBit,
    // Fault control and receive side
    input wire logic flip,
    output logic rxValid,
    output logic rxBit
);
    logic junk;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxValid <= 1'b0;
            junk <= 1'b0;
        end else begin
            rxValid <= txValid;
            junk <= ~junk;
        end
    end
    // Outside a payload bit the data line shows a changing pattern
    assign rxBit = rxValid ? (txBit ^ flip) : junk;
endmodule

//--- bench/bpg_bert_test.sv
// Self-checking bench for the bit-error-rate test block
`timescale 1ns/1ps
module bpg_bert_test;
    import bpg_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic txValid = 1'b0;
    logic txBit;
    logic rxValid;
    logic rxBit;
    logic manualErrorInsertIn = 1'b0;
    logic irqN;
    logic flip = 1'b0;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [31:0] rdata;
    logic perr;
    logic [31:0] g;
    bpg_ctrl_s cfg;

    always #25 clk = ~clk;

    bpg_bert i_dut (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .txValid(txValid), .txBit(txBit), .rxValid(rxValid),
        .rxBit(rxBit), .manualErrorInsertIn(manualErrorInsertIn), .irqN(irqN));
    bpg_line_model i_line (.clk(clk), .rstn(rstn), .txValid(txValid), .txBit(txBit),
        .flip(flip), .rxValid(rxValid), .rxBit(rxBit));

    // ==========================================================
    // Reporting and comparison
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %b got %b", what, exp, got);
        end
    endtask

    // ==========================================================
    // APB master
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0000_0000);
        chk32($sformatf("reg %h", a), exp & m, rdata & m);
    endtask
    task automatic perf();
        cfg.perfUpdateRequest = 1'b1;
        wr(OFS_CTRL, cfg);
        cfg.perfUpdateRequest = 1'b0;
    endtask

    // ==========================================================
    // Payload stream with optional transmit pattern check
    task automatic send(input int nb, input logic chk);
        logic fb;
        logic o;
        repeat (nb) begin
            @(posedge clk);
            txValid <= 1'b1;
            @(posedge clk);
            txValid <= 1'b0;
            if (chk) begin
                #1;
                fb = cfg.quasiRandomMode ? g[16] ^ g[19] : g[cfg.lenN];
                if (!cfg.repetitive && !cfg.quasiRandomMode) fb = fb ^ g[cfg.tapY];
                if (!cfg.repetitive && g[30:0] == 31'h0) fb = 1'b1;
                o = (cfg.quasiRandomMode && g[13:0] == 14'h0) ? 1'b1 : fb;
                g = {g[30:0], fb};
                chk1("txBit", o ^ cfg.invert, txBit);
            end
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic mode(input logic rep, input logic qr, input logic inv, input int n,
        input int y);
        cfg = '0;
        cfg.repetitive = rep;
        cfg.quasiRandomMode = qr;
        cfg.invert = inv;
        cfg.lenN = 5'(n - 1);
        cfg.tapY = 5'(y - 1);
    endtask
    task automatic txrun(input logic [31:0] seed, input int nb);
        wr(OFS_SEED, seed);
        wr(OFS_CTRL, cfg);
        cfg.txPatternLoad = 1'b1;
        cfg.rxPatternLoad = 1'b1;
        wr(OFS_CTRL, cfg);
        g = seed & 32'((64'h1 << (cfg.lenN + 6'd1)) - 64'h1);
        send(nb, 1'b1);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd(OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(OFS_SEED, SEED_RESET, 32'hFFFF_FFFF);
        rd(OFS_LIVE, 32'h0000_0008, 32'h0000_0008);
        chk1("irqN", 1'b1, irqN);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk1("pslverr", 1'b1, perr);
        chk32("unmapped", 32'h0000_0000, rdata);
        chk1("pready", 1'b1, pready);
        mode(0, 0, 0, 7, 6);
        txrun(32'hFFFF_FFFF, 40);
        mode(0, 0, 0, 7, 6);
        txrun(32'h0000_0000, 10);
        mode(0, 1, 0, 20, 3);
        txrun(32'hFFFF_FFFF, 60);
        mode(1, 0, 1, 32, 1);
        txrun(32'h8421_0F0F, 40);
        mode(1, 0, 0, 4, 1);
        txrun(32'h0000_0009, 80);
        rd(OFS_LIVE, 32'h0000_0000, 32'h0000_0008);
        mode(0, 0, 0, 7, 6);
        txrun(32'h0000_007F, 80);
        rd(OFS_LIVE, 32'h0000_0000, 32'h0000_0008);
        wr(OFS_IRQ_EN, 32'h0000_0002);
        perf();
        rd(OFS_LATCHED, 32'h0000_0001, 32'h0000_0001);
        ce <= 1'b0;
        send(5, 1'b0);
        ce <= 1'b1;
        send(50, 1'b0);
        perf();
        rd(OFS_BIT_COUNT, 32'd50, 32'hFFFF_FFFF);
        rd(OFS_ERR_COUNT, 32'd0, 32'hFFFF_FFFF);
        rd(OFS_LATCHED, 32'h0000_0001, 32'h0000_000F);
        chk1("irqN", 1'b1, irqN);
        cfg.singleErrReq = 1'b1;
        wr(OFS_CTRL, cfg);
        cfg.singleErrReq = 1'b0;
        send(20, 1'b0);
        chk1("irqN", 1'b0, irqN);
        rd(OFS_LIVE, 32'h0000_0004, 32'h0000_000C);
        chk1("irqN", 1'b0, irqN);
        rd(OFS_LATCHED, 32'h0000_0006, 32'h0000_000F);
        #1;
        chk1("irqN", 1'b1, irqN);
        rd(OFS_LATCHED, 32'h0000_0000, 32'h0000_000F);
        perf();
        rd(OFS_ERR_COUNT, 32'd1, 32'hFFFF_FFFF);
        rd(OFS_BIT_COUNT, 32'd20, 32'hFFFF_FFFF);
        cfg.manualSel = 1'b1;
        cfg.writeOneClearSel = 1'b1;
        wr(OFS_CTRL, cfg);
        perf();
        wr(OFS_LATCHED, 32'h0000_000F);
        rd(OFS_LATCHED, 32'h0000_0000, 32'h0000_000F);
        for (int t = 0; t < 2; t++) begin
            manualErrorInsertIn <= ~manualErrorInsertIn;
            cfg.singleErrReq = 1'b1;
            wr(OFS_CTRL, cfg);
            cfg.singleErrReq = 1'b0;
            send(20, 1'b0);
            perf();
            rd(OFS_ERR_COUNT, 32'd1, 32'hFFFF_FFFF);
        end
        rd(OFS_LATCHED, 32'h0000_0002, 32'h0000_000A);
        chk1("irqN", 1'b0, irqN);
        wr(OFS_LATCHED, 32'h0000_0002);
        rd(OFS_LATCHED, 32'h0000_0000, 32'h0000_0002);
        chk1("irqN", 1'b1, irqN);
        cfg.manualSel = 1'b0;
        cfg.resyncDisable = 1'b1;
        for (int r = 1; r < 3; r++) begin
            cfg.errRate = 3'(r);
            wr(OFS_CTRL, cfg);
            perf();
            send(100, 1'b0);
            perf();
            rd(OFS_ERR_COUNT, (r == 1) ? 32'd10 : 32'd1, 32'hFFFF_FFFF);
            rd(OFS_LIVE, 32'h0000_0000, 32'h0000_0008);
        end
        cfg.errRate = 3'd0;
        cfg.resyncDisable = 1'b0;
        wr(OFS_CTRL, cfg);
        flip <= 1'b1;
        send(11, 1'b0);
        flip <= 1'b0;
        rd(OFS_LIVE, 32'h0000_0008, 32'h0000_0008);
        rd(OFS_LATCHED, 32'h0000_0008, 32'h0000_0008);
        perf();
        send(20, 1'b0);
        perf();
        rd(OFS_BIT_COUNT, 32'd0, 32'hFFFF_FFFF);
        rd(OFS_ERR_COUNT, 32'd0, 32'hFFFF_FFFF);
        report_and_stop();
    end
endmodule
